// *** hdl/sat_pkg.sv ***
// shared constants and carrier types for the sync and test pattern register bank
package sat_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PAT3_LOW = 8'h1d;
    localparam logic [7:0] ADDR_PAT3_HIGH = 8'h1e;
    localparam logic [7:0] ADDR_PAT4_LOW = 8'h1f;
    localparam logic [7:0] ADDR_PAT4_HIGH = 8'h20;
    localparam logic [7:0] ADDR_SIG_LOW = 8'h24;
    localparam logic [7:0] ADDR_SIG_HIGH = 8'h25;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h3a;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PAT_BYTE = 8'h00;
    localparam logic [2:0] RST_SYNC_CTRL = 3'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // sync control field positions
    // ------------------------------------------------------------
    localparam int SYNC_MASTER_BIT = 0;
    localparam int SYNC_DIV_EN_BIT = 1;
    localparam int SYNC_NEXT_ONLY_BIT = 2;
    localparam int SYNC_CTRL_WIDTH = 3;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } sat_reg_req_s;

    typedef struct packed {
        logic [15:0] pattern3;
        logic [15:0] pattern4;
    } sat_patterns_s;
endpackage

// *** hdl/sat_sync_pattern_regs.sv ***
// sync control, user test patterns 3/4 and self-test signature register bank
//
// How it works
// - no sync pulse reaches the divider unless master buffer enable is set
// - pulses pass to divider only while divider enable and master enable high
// - next-sync-only: first pulse aligns the divider, later pulses are dropped
// - after a next-sync-only alignment, divider enable bit clears itself
// - pattern 3 is 16 bits, low byte then high byte at next address
// - pattern 4 is 16 bits in two bytes, both reset to zero
`timescale 1ns/1ps
module sat_sync_pattern_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // byte register port from the serial port engine
    input sat_pkg::sat_reg_req_s regReq,
    output logic [7:0] rdData_r,
    output logic rdValid_r,
    // sync pin and divider side
    input wire logic syncPin,
    output logic syncBufEnable_r,
    output logic dividerSync_r,
    // pattern generator and self-test engine
    output sat_pkg::sat_patterns_s patterns_r,
    input wire logic [15:0] signature
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    function automatic logic hit(input sat_pkg::sat_reg_req_s req, input logic [7:0] addr);
        hit = req.wr && (req.addr == addr);
    endfunction

    wire wrPat3Low = hit(regReq, sat_pkg::ADDR_PAT3_LOW);
    wire wrPat3High = hit(regReq, sat_pkg::ADDR_PAT3_HIGH);
    wire wrPat4Low = hit(regReq, sat_pkg::ADDR_PAT4_LOW);
    wire wrPat4High = hit(regReq, sat_pkg::ADDR_PAT4_HIGH);
    wire wrSyncCtrl = hit(regReq, sat_pkg::ADDR_SYNC_CTRL);

    // ------------------------------------------------------------
    // pattern words
    // ------------------------------------------------------------
    logic [7:0] pat3Low_r;
    logic [7:0] pat3High_r;
    logic [7:0] pat4Low_r;
    logic [7:0] pat4High_r;
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            pat3Low_r <= sat_pkg::RST_PAT_BYTE;
            pat3High_r <= sat_pkg::RST_PAT_BYTE;
        end else begin
            if (wrPat3Low) pat3Low_r <= regReq.data;
            if (wrPat3High) pat3High_r <= regReq.data;
        end
    end
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            pat4Low_r <= sat_pkg::RST_PAT_BYTE;
            pat4High_r <= sat_pkg::RST_PAT_BYTE;
        end else begin
            if (wrPat4Low) pat4Low_r <= regReq.data;
            if (wrPat4High) pat4High_r <= regReq.data;
        end
    end
    wire sat_pkg::sat_patterns_s patterns_nxt = {wrPat3High ? regReq.data : pat3High_r,
                                                 wrPat3Low ? regReq.data : pat3Low_r,
                                                 wrPat4High ? regReq.data : pat4High_r,
                                                 wrPat4Low ? regReq.data : pat4Low_r};
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) patterns_r <= '0;
        else patterns_r <= patterns_nxt;
    end

    // ------------------------------------------------------------
    // sync pin qualification
    // ------------------------------------------------------------
    logic syncS1_r;
    logic syncS2_r;
    logic syncS3_r;
    logic syncLevel_r;
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            syncS1_r <= 1'b0;
            syncS2_r <= 1'b0;
            syncS3_r <= 1'b0;
            syncLevel_r <= 1'b0;
        end else begin
            syncS1_r <= syncPin;
            syncS2_r <= syncS1_r;
            syncS3_r <= syncS2_r;
            if (syncS2_r == syncS3_r) syncLevel_r <= syncS3_r;
        end
    end
    wire syncRise = (syncS2_r == syncS3_r) && syncS3_r && !syncLevel_r;

    // ------------------------------------------------------------
    // sync control register
    // ------------------------------------------------------------
    logic [2:0] syncCtrl_r;
    wire masterEn = syncCtrl_r[sat_pkg::SYNC_MASTER_BIT];
    wire divEn = syncCtrl_r[sat_pkg::SYNC_DIV_EN_BIT];
    wire nextOnly = syncCtrl_r[sat_pkg::SYNC_NEXT_ONLY_BIT];
    wire passPulse = masterEn && divEn && syncRise;
    // one-shot: divider enable drops after the first pulse
    wire oneShotDone = passPulse && nextOnly;
    wire [2:0] ctrlWritten = wrSyncCtrl ? regReq.data[2:0] : syncCtrl_r;
    wire [2:0] divEnMask = 3'h1 << sat_pkg::SYNC_DIV_EN_BIT;
    // self-clear of divider enable wins over a same-cycle write
    wire [2:0] syncCtrl_nxt = oneShotDone ? (ctrlWritten & ~divEnMask) : ctrlWritten;
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) syncCtrl_r <= sat_pkg::RST_SYNC_CTRL;
        else syncCtrl_r <= syncCtrl_nxt;
    end
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            dividerSync_r <= 1'b0;
            syncBufEnable_r <= 1'b0;
        end else begin
            dividerSync_r <= passPulse;
            syncBufEnable_r <= syncCtrl_nxt[sat_pkg::SYNC_MASTER_BIT];
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic [7:0] rdMux;
    // reserved bits zero, signature straight from engine
    always_comb begin
        case (regReq.addr)
            sat_pkg::ADDR_PAT3_LOW: rdMux = pat3Low_r;
            sat_pkg::ADDR_PAT3_HIGH: rdMux = pat3High_r;
            sat_pkg::ADDR_PAT4_LOW: rdMux = pat4Low_r;
            sat_pkg::ADDR_PAT4_HIGH: rdMux = pat4High_r;
            sat_pkg::ADDR_SIG_LOW: rdMux = signature[7:0];
            sat_pkg::ADDR_SIG_HIGH: rdMux = signature[15:8];
            sat_pkg::ADDR_SYNC_CTRL: rdMux = {5'h00, syncCtrl_r};
            default: rdMux = sat_pkg::UNMAPPED_READ;
        endcase
    end
    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            rdData_r <= 8'h00;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regReq.rd;
            if (regReq.rd) rdData_r <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    master_gate_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        dividerSync_r |-> $past(masterEn))
        else $error("divider sync without master enable");
    both_enables_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (masterEn && divEn && syncRise) |=> dividerSync_r)
        else $error("qualified sync pulse not passed");
    one_shot_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (dividerSync_r && $past(nextOnly) && !$past(wrSyncCtrl)) |-> !divEn ##1 !dividerSync_r)
        else $error("second pulse passed in next-sync-only");
    self_clear_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        oneShotDone |=> !syncCtrl_r[sat_pkg::SYNC_DIV_EN_BIT])
        else $error("divider enable not cleared after one-shot");
    pat3_word_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        wrPat3High |=> patterns_r.pattern3[15:8] == $past(regReq.data))
        else $error("pattern 3 high byte misplaced");
    pat4_word_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (wrPat4Low && !wrPat4High) |=> patterns_r.pattern4[7:0] == $past(regReq.data))
        else $error("pattern 4 low byte misplaced");
    reserved_zero_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (regReq.rd && regReq.addr == sat_pkg::ADDR_SYNC_CTRL) |=> rdData_r[7:3] == 5'h00)
        else $error("reserved sync bits read nonzero");
    sig_readback_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (regReq.rd && regReq.addr == sat_pkg::ADDR_SIG_HIGH) |=> rdData_r == $past(signature[15:8]))
        else $error("signature high read wrong");
    pat3_low_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        wrPat3Low |=> patterns_r.pattern3[7:0] == $past(regReq.data))
        else $error("pattern 3 low byte misplaced");
    pat4_high_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        wrPat4High |=> patterns_r.pattern4[15:8] == $past(regReq.data))
        else $error("pattern 4 high byte misplaced");
    continuous_pass_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        dividerSync_r |-> $past(divEn))
        else $error("divider sync without divider enable");
    master_off_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        !masterEn |=> !dividerSync_r)
        else $error("sync passed while master enable low");
    buffer_follows_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        syncBufEnable_r == masterEn)
        else $error("sync buffer enable differs from master bit");
    later_drop_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (nextOnly && !divEn && syncRise) |=> !dividerSync_r)
        else $error("later pulse passed after one-shot");
    sig_low_read_a: assert property (@(posedge clock) disable iff (!rstSync_r)
        (regReq.rd && regReq.addr == sat_pkg::ADDR_SIG_LOW) |=> rdData_r == $past(signature[7:0]))
        else $error("signature low read wrong");
endmodule

// *** tb/sat_host_model.sv ***
// host controller model driving the byte register port
`timescale 1ns/1ps
module sat_host_model (
    // clock
    input wire logic clock,
    // register port
    output sat_pkg::sat_reg_req_s regReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid
);
    initial regReq = '0;
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        regReq <= '{wr: wr, rd: !wr, addr: addr, data: data};
        @(negedge clock);
        regReq <= '0;
    endtask
    task automatic readByte(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        access(1'b0, addr, 8'h00);
        valid = rdValid;
        data = rdData;
    endtask
endmodule

// *** tb/test_sat_sync_pattern_regs.sv ***
// self-checking bench for the sync and test pattern register bank
`timescale 1ns/1ps
module test_sat_sync_pattern_regs;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic syncPin = 1'b0;
    logic [15:0] signature = 16'ha55a;
    sat_pkg::sat_reg_req_s regReq;
    logic [7:0] rdData_r;
    logic rdValid_r, syncBufEnable_r, dividerSync_r;
    sat_pkg::sat_patterns_s patterns_r;
    int errors = 0;
    int n_checks = 0;
    int syncCount = 0;
    always #2 clock = ~clock;
    always @(posedge clock) if (dividerSync_r === 1'b1) syncCount <= syncCount + 1;
    sat_sync_pattern_regs i_dut (.clock(clock), .rst_n(rst_n), .regReq(regReq), .rdData_r(rdData_r),
        .rdValid_r(rdValid_r), .syncPin(syncPin), .syncBufEnable_r(syncBufEnable_r),
        .dividerSync_r(dividerSync_r), .patterns_r(patterns_r), .signature(signature));
    sat_host_model i_host (.clock(clock), .regReq(regReq), .rdData(rdData_r), .rdValid(rdValid_r));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host.readByte(addr, d, v);
        check({15'h0000, v}, 16'h0001);
        check({8'h00, d}, {8'h00, exp});
    endtask
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        i_host.access(1'b1, addr, data);
    endtask
    task automatic pulseSync(input int pulses, input int expCount);
        int startCount;
        startCount = syncCount;
        repeat (pulses) begin
            @(negedge clock) syncPin = 1'b1;
            repeat (3) @(negedge clock);
            syncPin = 1'b0;
            repeat (3) @(negedge clock);
        end
        repeat (4) @(negedge clock);
        check(16'(syncCount - startCount), 16'(expCount));
    endtask
    task automatic testReset;
        readCheck(8'h1d, 8'h00);
        readCheck(8'h1e, 8'h00);
        readCheck(8'h1f, 8'h00);
        readCheck(8'h20, 8'h00);
        readCheck(8'h24, 8'h5a);
        readCheck(8'h25, 8'ha5);
        readCheck(8'h3a, 8'h00);
        check(patterns_r.pattern3, 16'h0000);
        check(patterns_r.pattern4, 16'h0000);
    endtask
    task automatic testMidReset;
        writeReg(8'h3a, 8'h07);
        @(negedge clock) rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        check(patterns_r.pattern3, 16'h0000);
        check(patterns_r.pattern4, 16'h0000);
        check({15'h0000, syncBufEnable_r}, 16'h0000);
        readCheck(8'h3a, 8'h00);
        readCheck(8'h20, 8'h00);
    endtask
    task automatic testPatterns;
        writeReg(8'h1d, 8'h11);
        writeReg(8'h1e, 8'h22);
        writeReg(8'h1f, 8'h33);
        writeReg(8'h20, 8'h44);
        check(patterns_r.pattern3, 16'h2211);
        check(patterns_r.pattern4, 16'h4433);
        readCheck(8'h1e, 8'h22);
        readCheck(8'h1f, 8'h33);
    endtask
    task automatic testReadOnly;
        writeReg(8'h24, 8'hff);
        writeReg(8'h25, 8'hff);
        writeReg(8'h3a, 8'hf8);
        writeReg(8'h30, 8'h77);
        readCheck(8'h24, 8'h5a);
        readCheck(8'h25, 8'ha5);
        readCheck(8'h3a, 8'h00);
        readCheck(8'h30, 8'h00);
        @(negedge clock) signature = 16'h3cc3;
        readCheck(8'h24, 8'hc3);
        readCheck(8'h25, 8'h3c);
    endtask
    task automatic testSyncGate;
        pulseSync(1, 0);
        writeReg(8'h3a, 8'h02);
        pulseSync(1, 0);
        writeReg(8'h3a, 8'h01);
        check({15'h0000, syncBufEnable_r}, 16'h0001);
        pulseSync(1, 0);
        writeReg(8'h3a, 8'h03);
        pulseSync(2, 2);
        readCheck(8'h3a, 8'h03);
    endtask
    task automatic testNextOnly;
        writeReg(8'h3a, 8'h07);
        pulseSync(3, 1);
        readCheck(8'h3a, 8'h05);
        writeReg(8'h3a, 8'h00);
        check({15'h0000, syncBufEnable_r}, 16'h0000);
    endtask
    task automatic stop_test;
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        testReset();
        testPatterns();
        testMidReset();
        testReadOnly();
        testSyncGate();
        testNextOnly();
        stop_test();
    end
    // watchdog, well past the expected run
    initial begin
        #20000;
        errors++;
        stop_test();
    end
endmodule
